/* File: rtl/ofc_pkg.sv */
// constants and types for the overcurrent fuse cut controller
package ofc_pkg;
  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [7:0] OFS_DELAY_EN = 8'h08;
  localparam logic [7:0] OFS_CUT_CFG = 8'h09;
  localparam logic [7:0] OFS_THR_SEL = 8'h0a;
  localparam logic [7:0] OFS_ALM_LVL = 8'h13;
  localparam logic [7:0] OFS_ALM_DLY = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h27;
  localparam logic [7:0] OFS_CUT_CMD = 8'h53;
  localparam logic [7:0] OFS_GPIO_SEL = 8'h60;
  // field positions in the delay/enable register
  localparam int F_OC_EN = 0;
  localparam int F_DLY1_LO = 1;
  localparam int F_DLY2_LO = 4;
  localparam int F_OV_EN = 8;
  // field positions in the cut config register
  localparam int F_HOLD_LO = 0;
  localparam int F_MON_EN = 4;
  // threshold select field
  localparam int F_THS_LO = 12;
  // alarm level / delay fields: charge, discharge, short circuit
  localparam int F_ALM_W = 5;
  localparam int N_ALM = 3;
  // status register bits
  localparam int F_ST_DONE = 4;
  localparam int F_ST_ACTIVE = 3;
  // writable masks
  localparam logic [15:0] MSK_DELAY_EN = 16'hffff;
  localparam logic [15:0] MSK_CUT_CFG = 16'h00ff;
  localparam logic [15:0] MSK_THR_SEL = 16'h3fff;
  localparam logic [15:0] MSK_ALM = 16'h7fff;
  localparam logic [15:0] MSK_CMD = 16'h00ff;
  localparam logic [15:0] MSK_GPIO = 16'h0003;
  // reset values
  localparam logic [15:0] RST_CFG = 16'h0000;
  // direct cut code
  localparam logic [7:0] CUT_CODE = 8'hfb;
  // alarm level scaling: 5-bit level into a 17-bit magnitude
  localparam int LVL_SHIFT = 10;
  // selectable cut current thresholds, magnitude units
  localparam logic [16:0] CUT_THR_0 = 17'h01000;
  localparam logic [16:0] CUT_THR_1 = 17'h02000;
  localparam logic [16:0] CUT_THR_2 = 17'h03000;
  localparam logic [16:0] CUT_THR_3 = 17'h04000;
  // timing: one alarm delay step and one fuse delay step
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ALM_UNIT_PS = 1000000;
  localparam int FUSE_UNIT_PS = 1000000000;
  localparam int US_CYCLES = ALM_UNIT_PS / CLK_PERIOD_PS;
  localparam int MS_CYCLES = FUSE_UNIT_PS / CLK_PERIOD_PS;
  // number of pins the gate may be routed to
  localparam int N_GPIO = 3;
  // decision states
  typedef enum logic [1:0] {
    OFC_IDLE,
    OFC_DLY1,
    OFC_DLY2,
    OFC_CUT
  } ofc_state_t;
endpackage : ofc_pkg

/* File: rtl/ofc_fuse_ctrl.sv */
// overcurrent fuse cut decision, direct cut command and registers
//
// Decided for this implementation: the address-and-strobe port.
module ofc_fuse_ctrl
  import ofc_pkg::*;
#(
  parameter int TICK_MS_CYCLES = MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [15:0] measured_current,
  output logic [N_GPIO-1:0] gpio_fuse_gate
);

  localparam int PW = $clog2(TICK_MS_CYCLES + 1);
  localparam logic [PW-1:0] TICK_LAST = PW'(TICK_MS_CYCLES - 1);
  localparam logic [7:0] US_LAST = 8'(US_CYCLES - 1);

  // configuration registers, all sixteen bits
  logic [15:0] dly_en_reg, dly_en_next;
  logic [15:0] cut_cfg_reg, cut_cfg_next;
  logic [15:0] thr_sel_reg, thr_sel_next;
  logic [15:0] alm_lvl_reg, alm_lvl_next;
  logic [15:0] alm_dly_reg, alm_dly_next;
  logic [15:0] cmd_reg, cmd_next;
  logic [15:0] gpio_sel_reg, gpio_sel_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] status_word;

  // decision state
  ofc_state_t st_reg, st_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [PW-1:0] pre_reg, pre_next;
  logic direct_reg, direct_next;
  logic done_reg, done_next;
  logic [N_GPIO-1:0] gate_reg, gate_next;

  // alarm detection
  logic [7:0] us_reg, us_next;
  logic us_tick;
  logic [16:0] pos_mag, neg_mag;
  logic [16:0] mag_ch [N_ALM];
  logic [N_ALM-1:0] alarm;
  logic any_alarm;

  // decoded strobes and compares
  logic wr_cmd;
  logic direct_start;
  logic direct_stop;
  logic oc_en;
  logic ov_en;
  logic mon_en;
  logic over_cut;
  logic [16:0] cut_thr;
  logic ms_tick;

  assign oc_en = dly_en_reg[F_OC_EN];
  assign ov_en = dly_en_reg[F_OV_EN];
  assign mon_en = cut_cfg_reg[F_MON_EN];

  // signed current split into charge and discharge magnitudes
  always_comb begin
    pos_mag = measured_current[15] ? 17'h00000
                                   : {1'b0, measured_current};
    neg_mag = measured_current[15]
            ? 17'h00000 - {measured_current[15], measured_current}
            : 17'h00000;
  end

  // channel 0 charge, channels 1 and 2 discharge and short
  always_comb begin
    mag_ch[0] = pos_mag;
    mag_ch[1] = neg_mag;
    mag_ch[2] = neg_mag;
  end

  // free running microsecond step for the alarm delays
  always_comb begin
    us_tick = (us_reg == US_LAST);
    us_next = us_tick ? 8'h00 : us_reg + 8'h01;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      us_reg <= 8'h00;
    end else begin
      us_reg <= us_next;
    end
  end

  // one persistence counter per alarm source
  genvar g;
  generate
    for (g = 0; g < N_ALM; g++) begin : g_alm
      logic [5:0] acnt_reg, acnt_next;
      logic [5:0] target;
      logic [16:0] lvl_thr;
      logic over_lvl;
      always_comb begin
        // coarse level steps keep the compare a plain magnitude test
        lvl_thr = 17'(alm_lvl_reg[g*F_ALM_W +: F_ALM_W])
                << LVL_SHIFT;
        target = {1'b0, alm_dly_reg[g*F_ALM_W +: F_ALM_W]}
               + 6'h01;
        over_lvl = (mag_ch[g] > lvl_thr);
        if (!over_lvl) begin
          acnt_next = 6'h00;
        end else if (us_tick && acnt_reg != target) begin
          acnt_next = acnt_reg + 6'h01;
        end else begin
          acnt_next = acnt_reg;
        end
      end
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          acnt_reg <= 6'h00;
        end else begin
          acnt_reg <= acnt_next;
        end
      end
      // alarm stands only while level held the whole delay
      assign alarm[g] = (acnt_reg == target);
    end
  endgenerate

  assign any_alarm = |alarm;

  // selectable cut threshold
  always_comb begin
    case (thr_sel_reg[F_THS_LO +: 2])
      2'h0: cut_thr = CUT_THR_0;
      2'h1: cut_thr = CUT_THR_1;
      2'h2: cut_thr = CUT_THR_2;
      default: cut_thr = CUT_THR_3;
    endcase
    // either direction of flow counts as abnormal
    over_cut = (pos_mag > cut_thr) || (neg_mag > cut_thr);
  end

  // direct cut command decode
  always_comb begin
    wr_cmd = reg_wr && (reg_addr == OFS_CUT_CMD);
    direct_start = wr_cmd && ov_en
                 && (reg_wdata[7:0] == CUT_CODE);
    direct_stop = wr_cmd
                && (reg_wdata[7:0] != CUT_CODE);
  end

  // decision state machine
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    direct_next = direct_reg;
    done_next = done_reg;
    case (st_reg)
      OFC_IDLE: begin
        if (direct_start) begin
          st_next = OFC_CUT;
          direct_next = 1'b1;
          cnt_next = {1'b0, cut_cfg_reg[F_HOLD_LO +: 4]} + 5'h01;
        end else if (oc_en && any_alarm) begin
          st_next = OFC_DLY1;
          cnt_next = {2'b00, dly_en_reg[F_DLY1_LO +: 3]}
                   + 5'h01;
        end
      end
      OFC_DLY1: begin
        if (direct_start) begin
          st_next = OFC_CUT;
          direct_next = 1'b1;
          cnt_next = {1'b0, cut_cfg_reg[F_HOLD_LO +: 4]} + 5'h01;
        end else if (!oc_en) begin
          st_next = OFC_IDLE;
          cnt_next = 5'h00;
        end else if (ms_tick && cnt_reg == 5'h01) begin
          st_next = OFC_DLY2;
          cnt_next = {1'b0, dly_en_reg[F_DLY2_LO +: 4]}
                   + 5'h01;
        end else if (ms_tick) begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      OFC_DLY2: begin
        if (direct_start) begin
          st_next = OFC_CUT;
          direct_next = 1'b1;
          cnt_next = {1'b0, cut_cfg_reg[F_HOLD_LO +: 4]} + 5'h01;
        end else if (!oc_en) begin
          st_next = OFC_IDLE;
          cnt_next = 5'h00;
        end else if (!over_cut) begin
          st_next = OFC_IDLE;
          cnt_next = 5'h00;
        end else if (ms_tick && cnt_reg == 5'h01) begin
          st_next = OFC_CUT;
          direct_next = 1'b0;
          cnt_next = {1'b0, cut_cfg_reg[F_HOLD_LO +: 4]} + 5'h01;
        end else if (ms_tick) begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      OFC_CUT: begin
        if (direct_reg && direct_stop) begin
          st_next = OFC_IDLE;
          direct_next = 1'b0;
          cnt_next = 5'h00;
        end else if (!direct_reg && mon_en && !over_cut) begin
          st_next = OFC_IDLE;
          cnt_next = 5'h00;
        end else if (ms_tick && cnt_reg == 5'h01) begin
          // expiry ends the cut for both sources
          st_next = OFC_IDLE;
          direct_next = 1'b0;
          cnt_next = 5'h00;
          done_next = 1'b1;
        end else if (ms_tick) begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      default: begin
        st_next = OFC_IDLE;
        cnt_next = 5'h00;
      end
    endcase
  end

  // millisecond step restarts on every state change so each
  // delay lasts its full count of steps
  always_comb begin
    ms_tick = (pre_reg == TICK_LAST);
    if (st_next != st_reg || ms_tick) begin
      pre_next = '0;
    end else begin
      pre_next = pre_reg + PW'(1);
    end
  end

  // gate drive routed to the selected pin only
  generate
    for (g = 0; g < N_GPIO; g++) begin : g_pin
      always_comb begin
        gate_next[g] = (st_next == OFC_CUT)
                     && (gpio_sel_reg[1:0] == 2'(g));
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= OFC_IDLE;
      cnt_reg <= 5'h00;
      pre_reg <= '0;
      direct_reg <= 1'b0;
      done_reg <= 1'b0;
      gate_reg <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      pre_reg <= pre_next;
      direct_reg <= direct_next;
      done_reg <= done_next;
      gate_reg <= gate_next;
    end
  end

  assign gpio_fuse_gate = gate_reg;

  // status: completed flag, cut active, live alarms
  always_comb begin
    status_word = 16'h0000;
    status_word[F_ST_DONE] = done_reg;
    status_word[F_ST_ACTIVE] = (st_reg == OFC_CUT);
    status_word[N_ALM-1:0] = alarm;
  end

  // register writes; unwritable bits stay zero
  always_comb begin
    dly_en_next = dly_en_reg;
    cut_cfg_next = cut_cfg_reg;
    thr_sel_next = thr_sel_reg;
    alm_lvl_next = alm_lvl_reg;
    alm_dly_next = alm_dly_reg;
    cmd_next = cmd_reg;
    gpio_sel_next = gpio_sel_reg;
    if (reg_wr) begin
      if (reg_addr == OFS_DELAY_EN) begin
        dly_en_next = reg_wdata & MSK_DELAY_EN;
      end else if (reg_addr == OFS_CUT_CFG) begin
        cut_cfg_next = reg_wdata & MSK_CUT_CFG;
      end else if (reg_addr == OFS_THR_SEL) begin
        thr_sel_next = reg_wdata & MSK_THR_SEL;
      end else if (reg_addr == OFS_ALM_LVL) begin
        alm_lvl_next = reg_wdata & MSK_ALM;
      end else if (reg_addr == OFS_ALM_DLY) begin
        alm_dly_next = reg_wdata & MSK_ALM;
      end else if (reg_addr == OFS_CUT_CMD) begin
        cmd_next = reg_wdata & MSK_CMD;
      end else if (reg_addr == OFS_GPIO_SEL) begin
        gpio_sel_next = reg_wdata & MSK_GPIO;
      end
    end
  end

  // read data appears the cycle after the strobe, else zero
  always_comb begin
    rdata_next = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == OFS_DELAY_EN) begin
        rdata_next = dly_en_reg;
      end else if (reg_addr == OFS_CUT_CFG) begin
        rdata_next = cut_cfg_reg;
      end else if (reg_addr == OFS_THR_SEL) begin
        rdata_next = thr_sel_reg;
      end else if (reg_addr == OFS_ALM_LVL) begin
        rdata_next = alm_lvl_reg;
      end else if (reg_addr == OFS_ALM_DLY) begin
        rdata_next = alm_dly_reg;
      end else if (reg_addr == OFS_STATUS) begin
        rdata_next = status_word;
      end else if (reg_addr == OFS_CUT_CMD) begin
        rdata_next = cmd_reg;
      end else if (reg_addr == OFS_GPIO_SEL) begin
        rdata_next = gpio_sel_reg;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dly_en_reg <= RST_CFG;
      cut_cfg_reg <= RST_CFG;
      thr_sel_reg <= RST_CFG;
      alm_lvl_reg <= RST_CFG;
      alm_dly_reg <= RST_CFG;
      cmd_reg <= RST_CFG;
      gpio_sel_reg <= RST_CFG;
      rdata_reg <= 16'h0000;
    end else begin
      dly_en_reg <= dly_en_next;
      cut_cfg_reg <= cut_cfg_next;
      thr_sel_reg <= thr_sel_next;
      alm_lvl_reg <= alm_lvl_next;
      alm_dly_reg <= alm_dly_next;
      cmd_reg <= cmd_next;
      gpio_sel_reg <= gpio_sel_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule : ofc_fuse_ctrl

/* File: verification/ofc_fuse_checker.sv */
// port checker for the fuse cut controller
module ofc_fuse_checker
  import ofc_pkg::*;
#(
  parameter int TICK_MS_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [15:0] measured_current,
  input wire logic [N_GPIO-1:0] gpio_fuse_gate
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic [15:0] en_reg, cfg_reg, ths_reg, hi_reg, mag;
  logic [16:0] thr;
  logic dir_reg, mag_hi, gate, go, wr_cmd;
  int full;
  // live decode against the settings software last wrote
  always_comb begin
    gate = |gpio_fuse_gate;
    wr_cmd = reg_wr && reg_addr == OFS_CUT_CMD;
    go = wr_cmd && reg_wdata[7:0] == CUT_CODE && en_reg[F_OV_EN];
    mag = measured_current[15] ? -measured_current : measured_current;
    case (ths_reg[F_THS_LO+:2])
      2'h0: thr = CUT_THR_0;
      2'h1: thr = CUT_THR_1;
      2'h2: thr = CUT_THR_2;
      default: thr = CUT_THR_3;
    endcase
    mag_hi = {1'b0, mag} > thr;
    full = (int'(cfg_reg[F_HOLD_LO+:4]) + 1) * TICK_MS_CYCLES;
  end
  // shadows of the settings and the length of the running gate pulse
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      en_reg <= RST_CFG;
      cfg_reg <= RST_CFG;
      ths_reg <= RST_CFG;
      hi_reg <= 16'h0000;
      dir_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFS_DELAY_EN) en_reg <= reg_wdata;
      if (reg_wr && reg_addr == OFS_CUT_CFG) cfg_reg <= reg_wdata;
      if (reg_wr && reg_addr == OFS_THR_SEL) ths_reg <= reg_wdata;
      hi_reg <= gate ? hi_reg + 16'h0001 : 16'h0000;
      // the end of a pulse also ends the direct run it belonged to
      if (go) dir_reg <= 1'b1;
      else if (wr_cmd || (hi_reg != 16'h0000 && !gate)) dir_reg <= 1'b0;
    end
  end
  a_reset_quiet: assert property (
    $fell(sys_rst) |-> !gate && reg_rdata == 16'h0000) else $error("dirty reset");
  a_rd_slot: assert property (
    !reg_rd |=> reg_rdata == 16'h0000) else $error("stray read data");
  a_one_pin: assert property (
    $onehot0(gpio_fuse_gate)) else $error("gate on several pins");
  a_direct_go: assert property (
    go && !gate |=> gate) else $error("direct cut did not start");
  a_direct_full: assert property (
    $fell(gate) && dir_reg |-> int'(hi_reg) == full)
    else $error("direct cut length wrong");
  a_cmd_stop: assert property (
    wr_cmd && reg_wdata[7:0] != CUT_CODE && dir_reg |-> ##[1:3] !gate)
    else $error("direct cut not stopped");
  a_cut_cause: assert property (
    $rose(gate) |-> en_reg[F_OC_EN] || dir_reg) else $error("cut while off");
  a_cut_level: assert property (
    $rose(gate) && !dir_reg |-> $past(mag_hi))
    else $error("cut without high current");
  a_mon_abort: assert property (
    cfg_reg[F_MON_EN] && !dir_reg && gate && !mag_hi |-> ##[1:3] !gate)
    else $error("watched cut not aborted");
  c_direct: cover property ($fell(gate) && dir_reg);
  c_algo: cover property ($rose(gate) && !dir_reg);
  c_abort: cover property (cfg_reg[F_MON_EN] && gate && !mag_hi);
endmodule : ofc_fuse_checker
bind ofc_fuse_ctrl ofc_fuse_checker #(
  .TICK_MS_CYCLES(TICK_MS_CYCLES)
) ofc_fuse_checker_i (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .measured_current(measured_current),
  .gpio_fuse_gate(gpio_fuse_gate)
);

/* File: verification/ofc_fuse_model.sv */
// chemical fuse behind the external gate transistor, seen by the shunt
module ofc_fuse_model #(
  parameter int BLOW_CYCLES = 6
) (
  input wire logic clk_sys,
  input wire logic gate,
  input wire logic fuse_new,
  input wire logic [15:0] load_current,
  output logic [15:0] measured_current
);
  timeunit 1ns;
  timeprecision 1ps;
  int heat;
  logic open_reg;
  // the element opens after enough gate time and stays open until replaced
  always_ff @(posedge clk_sys) begin
    if (fuse_new) begin
      heat <= 0;
      open_reg <= 1'b0;
    end else begin
      heat <= gate ? heat + 1 : 0;
      if (heat >= BLOW_CYCLES) open_reg <= 1'b1;
    end
  end
  // an open fuse carries no current at all
  assign measured_current = open_reg ? 16'h0000 : load_current;
endmodule : ofc_fuse_model

/* File: verification/testbench.sv */
// self-checking bench for the fuse cut controller and its fuse
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module testbench
  import ofc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  logic clk_sys, sys_rst, reg_wr, reg_rd, fuse_new, rd_d;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, load_current, measured_current;
  logic [15:0] thr_v, cur;
  logic [N_GPIO-1:0] gpio_fuse_gate;
  logic [15:0] exp_q[$];
  logic [15:0] exp_v;
  int bad_count, n_checks, pin, ts, hi_len, last_len, n_pulse, cyc;
  logic [7:0] ofs[9] = '{OFS_DELAY_EN, OFS_CUT_CFG, OFS_THR_SEL, OFS_ALM_LVL,
    OFS_ALM_DLY, OFS_STATUS, OFS_CUT_CMD, OFS_GPIO_SEL, 8'h3f};
  logic [15:0] msk[9] = '{MSK_DELAY_EN, MSK_CUT_CFG, MSK_THR_SEL, MSK_ALM,
    MSK_ALM, 16'h0000, MSK_CMD, MSK_GPIO, 16'h0000};
  logic [16:0] thr_t[4] = '{CUT_THR_0, CUT_THR_1, CUT_THR_2, CUT_THR_3};
  ofc_fuse_ctrl #(.TICK_MS_CYCLES(TICK)) ofc_fuse_ctrl_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .measured_current(measured_current),
    .gpio_fuse_gate(gpio_fuse_gate));
  ofc_fuse_model ofc_fuse_model_i (
    .clk_sys(clk_sys), .gate(gpio_fuse_gate[pin]), .fuse_new(fuse_new),
    .load_current(load_current), .measured_current(measured_current));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // strobes stay up between back-to-back calls; idle drops them
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    exp_q.push_back(e);
    @(posedge clk_sys);
  endtask : rd
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask : idle
  task automatic new_fuse;
    fuse_new <= 1'b1;
    idle(1);
    fuse_new <= 1'b0;
  endtask : new_fuse
  task automatic wait_pulse(input int lim);
    int k;
    k = n_pulse;
    idle(0);
    repeat (lim) if (n_pulse == k) @(posedge clk_sys);
    `CHK(n_pulse, k + 1)
  endtask : wait_pulse
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // read data only in the slot after the strobe; gate pulses are timed
  always @(posedge clk_sys) begin
    if (rd_d) begin
      exp_v = exp_q.pop_front();
      `CHK(reg_rdata, exp_v)
    end
    rd_d <= reg_rd;
    if (gpio_fuse_gate[pin] === 1'b1) hi_len <= hi_len + 1;
    else if (hi_len != 0) begin
      last_len <= hi_len;
      n_pulse <= n_pulse + 1;
      hi_len <= 0;
    end
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_d = 1'b0;
    load_current = 16'h0000;
    fuse_new = 1'b1;
    sys_rst = 1'b1;
    void'($urandom(32'hd70d));
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    fuse_new <= 1'b0;
    @(posedge clk_sys);
    // reset values, writable masks, read-only status, unmapped hole
    foreach (ofs[i]) rd(ofs[i], 16'h0000);
    foreach (ofs[i]) wr(ofs[i], 16'hffff);
    foreach (ofs[i]) rd(ofs[i], msk[i]);
    foreach (ofs[i]) wr(ofs[i], 16'h0000);
    pin = $urandom % 3;
    wr(OFS_GPIO_SEL, 16'(pin));
    $display("test registers done");
    // cut code without the voltage enable is ignored; then a stopped cut
    wr(OFS_CUT_CFG, 16'h0003);
    wr(OFS_CUT_CMD, 16'h00fb);
    idle(40);
    `CHK(n_pulse, 0)
    wr(OFS_DELAY_EN, 16'h0100);
    wr(OFS_CUT_CMD, 16'h00fb);
    idle(3);
    wr(OFS_CUT_CMD, 16'h0042);
    idle(20);
    `CHK(n_pulse, 1)
    `CHK(last_len < 4 * TICK, 1'b1)
    rd(OFS_STATUS, 16'h0000);
    $display("test direct stop done");
    // no cut with the current enable clear, nor with current under limit
    ts = $urandom % 4;
    thr_v = thr_t[ts][15:0];
    wr(OFS_THR_SEL, 16'(ts) << F_THS_LO);
    cur = thr_v + 16'($urandom % 4096) + 16'h0001;
    load_current <= ($urandom % 2) ? -cur : cur;
    wr(OFS_DELAY_EN, 16'h0022);
    idle(1200);
    `CHK(n_pulse, 1)
    load_current <= thr_v - 16'h0100;
    wr(OFS_DELAY_EN, 16'h0023);
    idle(1200);
    `CHK(n_pulse, 1)
    $display("test no cut done");
    // enable dropped inside the second delay: its countdown is abandoned
    wr(OFS_DELAY_EN, 16'h00fe);
    load_current <= cur;
    wr(OFS_CUT_CFG, 16'h0013);
    repeat (30) begin
      wr(OFS_DELAY_EN, 16'h00ff);
      idle(50);
      wr(OFS_DELAY_EN, 16'h00fe);
    end
    `CHK(n_pulse, 1)
    rd(OFS_STATUS, 16'h0001);
    wr(OFS_ALM_LVL, 16'h7fff);
    idle(2);
    rd(OFS_STATUS, 16'h0000);
    wr(OFS_ALM_LVL, 16'h0000);
    $display("test enable drop done");
    // watched cut: the blown fuse drops the current, cut ends, no flag
    wr(OFS_DELAY_EN, 16'h0023);
    wait_pulse(1200);
    `CHK(last_len < 4 * TICK, 1'b1)
    idle(600);
    rd(OFS_STATUS, 16'h0000);
    $display("test abort done");
    // unwatched cut decided by the algorithm runs its full time
    wr(OFS_CUT_CFG, 16'h0001);
    new_fuse();
    wait_pulse(1200);
    `CHK(last_len, 2 * TICK)
    idle(600);
    rd(OFS_STATUS, 16'h0010);
    $display("test algorithm cut done");
    // direct cut with the current enable clear runs its full time
    wr(OFS_DELAY_EN, 16'h0100);
    wr(OFS_CUT_CFG, 16'h0002);
    new_fuse();
    wr(OFS_CUT_CMD, 16'h00fb);
    wait_pulse(100);
    `CHK(last_len, 3 * TICK)
    idle(600);
    rd(OFS_STATUS, 16'h0010);
    idle(3);
    $display("test direct cut done");
    wrap_up();
  end
endmodule : testbench
